// ===== logic/hbfe_pkg.sv
/*
  hbfe_pkg: constants, register map, tables and state type for the
  high band flatness / full-band energy parameter estimator.
  Assumes Q15 voicing, gain shape and pitch gain, Q12 frame gain and LPC.
*/
`default_nettype none
package hbfe_pkg;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int NWORDS = 16;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_LAG = 8'h08;
  localparam logic [7:0] REG_PGAIN = 8'h0C;
  localparam logic [7:0] REG_FGAIN = 8'h10;
  localparam logic [7:0] REG_GS = 8'h14;
  localparam logic [7:0] REG_VF = 8'h1C;
  localparam logic [7:0] REG_LPC = 8'h28;
  localparam int CTRL_START = 0;
  localparam int CTRL_PREV_TCX = 1;
  localparam int CTRL_RATE13 = 2;
  localparam int CTRL_STEEP_MODE = 3;
  localparam int CTRL_STEEP_OK = 4;
  localparam int CTRL_GENTLE_OK = 5;
  localparam int SEG_N = 16;
  localparam int SEG_LEN = 20;
  localparam int FRAME_LEN = 320;
  localparam int ORI_LEN = 960;
  localparam int LPC_ORD = 11;
  localparam int GS_N = 4;
  localparam int VF_N = 5;
  localparam int Q15 = 15;
  localparam int LPC_FRAC = 12;
  localparam int GF_FRAC = 12;
  localparam int TAB_FRAC = 14;
  localparam int LOG_FRAC = 4;
  localparam int TAB_SCALE_LOG2 = 20;
  localparam int IDX_MAX = 15;
  localparam real FLAT_HI = 0.7;
  localparam real FLAT_LO = 0.5;
  localparam real PGAIN_TH = 0.7;
  localparam int LAG_TH = 100;
  localparam int FL_HI_LOG = int'($ln(FLAT_HI) / $ln(2.0) * 16.0);
  localparam int FL_LO_LOG = int'($ln(FLAT_LO) / $ln(2.0) * 16.0);
  localparam logic [16:0] PGAIN_TH2 = 17'(int'(2.0 * PGAIN_TH * 32768.0));
  localparam logic [16:0] LAG_TH2 = 17'(2 * LAG_TH);
  localparam logic signed [17:0] MU_MAX = 18'(int'(0.68 * 32768.0));
  localparam logic signed [17:0] MU_MIN = 18'(int'(0.48 * 32768.0));
  localparam logic [15:0] VF_FIFTH = 16'(int'(0.2 * 32768.0));
  localparam logic signed [15:0] BP_C = 16'sh2D41;
  localparam logic signed [15:0] CORR_TAB [0:31] = '{
    16'sh4000, 16'sh3EC5, 16'sh3B21, 16'sh3537, 16'sh3537, 16'sh238E,
    16'sh187E, 16'sh0C7C, 16'sh0000, 16'shF384, 16'shE782, 16'shDC72,
    16'shD2BF, 16'shCAC9, 16'shC4DF, 16'shC13B, 16'shC000, 16'shC13B,
    16'shC4DF, 16'shCAC9, 16'shD2BF, 16'shDC72, 16'shE782, 16'shF384,
    16'sh0000, 16'sh0C7C, 16'sh187E, 16'sh238E, 16'sh2D41, 16'sh3537,
    16'sh3B21, 16'sh3EC5};
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {ST_IDLE, ST_TGT, ST_SYN, ST_ORI, ST_DONE}
    hbfe_state_t;
endpackage
`default_nettype wire

// ===== logic/hbfe_top.sv
/*
  hbfe_top: per-frame temporal flatness flag, joint 2-bit side code and
  4-bit full-band energy ratio index, with an AXI4-Lite register slave.
  Assumes one sample stream from same-clock logic, in frame order:
  320 target, 320 noise, 960 original input samples.
*/
// Implementation choices: register access over AXI4-Lite and the register addresses.
`default_nettype none
module hbfe_top
  import hbfe_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  input  wire logic [hbfe_pkg::AW-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [hbfe_pkg::DW-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [hbfe_pkg::AW-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [hbfe_pkg::DW-1:0]    s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  s_valid,
  output logic                       s_ready,
  input  wire logic [15:0]           s_data,
  output logic                       res_valid,
  output logic [1:0]                 res_code,
  output logic [3:0]                 res_idx,
  output logic                       res_flat
);
  localparam int W_CTRL = int'(REG_CTRL) / 4;
  localparam int W_STAT = int'(REG_STAT) / 4;
  localparam int H_LAG = int'(REG_LAG) / 2;
  localparam int H_PG = int'(REG_PGAIN) / 2;
  localparam int H_GF = int'(REG_FGAIN) / 2;
  localparam int H_GS = int'(REG_GS) / 2;
  localparam int H_VF = int'(REG_VF) / 2;
  localparam int H_LPC = int'(REG_LPC) / 2;

  // log2 in Q4: msb position and four bits below it as a linear fraction
  function automatic logic signed [11:0] log2q(input logic [63:0] v);
    logic [5:0]  pos;
    logic [63:0] sh;
    pos = 6'd0;
    for (int i = 0; i < 64; i++)
      if (v[i])
        pos = 6'(i);
    sh = v << (6'd63 - pos);
    return {2'b00, pos, sh[62:59]};
  endfunction

  hbfe_state_t  st_q, st_d;
  logic [31:0]  regs_q [NWORDS];
  logic [31:0]  regs_d [NWORDS];
  logic [15:0]  half_w [2*NWORDS];
  logic [AW-1:0] awaddr_q, awaddr_d;
  logic [31:0]  wdata_q, wdata_d;
  logic [3:0]   wstrb_q, wstrb_d;
  logic         aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic         bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]   bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]  rdata_q, rdata_d, status_w;
  logic         wr_fire, wr_map, start_w, done_q, done_d;
  logic [9:0]   cnt_q, cnt_d;
  logic [4:0]   seg_cnt_q, seg_cnt_d;
  logic [36:0]  seg_e_q, seg_e_d;
  logic [40:0]  tot_e_q, tot_e_d;
  logic signed [15:0] logsum_q, logsum_d;
  logic signed [23:0] yh_q [LPC_ORD];
  logic signed [23:0] yh_d [LPC_ORD];
  logic signed [23:0] fprev_q, fprev_d;
  logic signed [15:0] x1_q, x1_d, x2_q, x2_d;
  logic [63:0]  syn_e_q, syn_e_d, ori_e_q, ori_e_d;
  logic         rv_q, rv_d, flat_q, flat_d;
  logic [1:0]   code_q, code_d;
  logic [3:0]   idx_q, idx_d;
  logic signed [17:0] mu_w;
  logic [16:0]  lsum_w, gsum_w;
  logic [1:0]   onset_w;
  logic signed [15:0] fl_diff_w;
  logic         flag_w;

  always_comb
  begin
    for (int i = 0; i < NWORDS; i++)
    begin
      half_w[2*i] = regs_q[i][15:0];
      half_w[2*i+1] = regs_q[i][31:16];
    end
  end

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wr_map = awaddr_q < AW'(NWORDS * 4);
  // a start while a frame runs is dropped, so one frame cannot be torn
  assign start_w = wr_fire && wr_map && awaddr_q[5:2] == 4'(W_CTRL)
                   && wstrb_q[0] && wdata_q[CTRL_START] && st_q == ST_IDLE;
  assign status_w = {23'h00_0000, flat_q, idx_q, code_q, done_q,
                     st_q != ST_IDLE};

  always_comb
  begin
    aw_have_d = aw_have_q;
    awaddr_d = awaddr_q;
    w_have_d = w_have_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    regs_d = regs_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      if (wr_map && awaddr_q[5:2] != 4'(W_STAT))
        for (int b = 0; b < 4; b++)
          if (wstrb_q[b])
            regs_d[awaddr_q[5:2]][8*b +: 8] = wdata_q[8*b +: 8];
      regs_d[W_CTRL][CTRL_START] = 1'b0;
      bresp_d = wr_map ? RESP_OKAY : RESP_SLVERR;
      bvalid_d = 1'b1;
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
    end
    else if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d = RESP_SLVERR;
      rdata_d = 32'h0000_0000;
      if (s_axi_araddr < AW'(NWORDS * 4))
      begin
        rresp_d = RESP_OKAY;
        rdata_d = (s_axi_araddr[5:2] == 4'(W_STAT)) ? status_w
                  : regs_q[s_axi_araddr[5:2]];
      end
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
      w_have_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
      for (int i = 0; i < NWORDS; i++)
        regs_q[i] <= 32'h0000_0000;
    end
    else if (ce)
    begin
      aw_have_q <= aw_have_d;
      awaddr_q <= awaddr_d;
      w_have_q <= w_have_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      regs_q <= regs_d;
    end
  end

  // frame decision terms from the software-written parameters and the target-phase segment and total energies
  always_comb
  begin
    logic [18:0] vsum;
    logic [34:0] vprod;
    logic [15:0] vm;
    logic [31:0] m2, m3;
    vprod = 35'h0_0000_0000;
    vm = 16'h0000;
    vsum = 19'h0_0000;
    for (int i = 0; i < VF_N - 1; i++)
      vsum = vsum + 19'(half_w[H_VF + i]);
    if (regs_q[W_CTRL][CTRL_RATE13])
      vm = 16'(vsum >> 2);
    else
    begin
      vsum = vsum + 19'(half_w[H_VF + VF_N - 1]);
      vprod = 35'(vsum) * 35'(VF_FIFTH);
      vm = 16'(vprod >> Q15);
    end
    m2 = (32'(vm) * 32'(vm)) >> Q15;
    m3 = (32'(m2[15:0]) * 32'(vm)) >> Q15;
    mu_w = MU_MAX - $signed({2'b00, m3[15:0]});
    if (mu_w < MU_MIN)
      mu_w = MU_MIN;
    lsum_w = 17'(half_w[H_LAG]) + 17'(half_w[H_LAG + 1]);
    gsum_w = 17'(half_w[H_PG]) + 17'(half_w[H_PG + 1]);
    fl_diff_w = (logsum_q >>> LOG_FRAC) - 16'(log2q(64'(tot_e_q) + 64'd16)
                - 12'sd64);
    if (regs_q[W_CTRL][CTRL_PREV_TCX])
      flag_w = fl_diff_w > 16'(FL_LO_LOG) && gsum_w < PGAIN_TH2;
    else
      flag_w = fl_diff_w > 16'(FL_HI_LOG) && lsum_w > LAG_TH2
               && gsum_w > PGAIN_TH2;
    if (regs_q[W_CTRL][CTRL_STEEP_MODE])
      onset_w = regs_q[W_CTRL][CTRL_STEEP_OK] ? 2'd2 : 2'd0;
    else
      onset_w = regs_q[W_CTRL][CTRL_GENTLE_OK] ? 2'd1 : 2'd0;
  end

  always_comb
  begin
    logic signed [15:0] sx;
    logic signed [43:0] acc, yf;
    logic signed [39:0] p1, p2, p3;
    logic signed [23:0] y, c, f, d, g1, g2, bp;
    logic signed [15:0] r16;
    logic [1:0]   sel;
    sx = $signed(s_data);
    acc = 44'sd0;
    st_d = st_q;
    cnt_d = cnt_q;
    seg_cnt_d = seg_cnt_q;
    seg_e_d = seg_e_q;
    tot_e_d = tot_e_q;
    logsum_d = logsum_q;
    yh_d = yh_q;
    fprev_d = fprev_q;
    x1_d = x1_q;
    x2_d = x2_q;
    syn_e_d = syn_e_q;
    ori_e_d = ori_e_q;
    done_d = done_q;
    rv_d = 1'b0;
    flat_d = flat_q;
    code_d = code_q;
    idx_d = idx_q;
    for (int k = 0; k < LPC_ORD; k++)
      acc = acc + 44'(yh_q[k] * $signed(half_w[H_LPC + k]));
    yf = 44'(sx) - (acc >>> LPC_FRAC);
    y = yf[23:0];
    p1 = y * CORR_TAB[cnt_q[4:0]];
    c = 24'(p1 >>> TAB_FRAC);
    f = cnt_q[0] ? c : -c;
    p2 = 40'(fprev_q * mu_w);
    d = f - 24'(p2 >>> Q15);
    sel = 2'(cnt_q / 10'(FRAME_LEN / GS_N));
    p3 = 40'(d * $signed({1'b0, half_w[H_GF]}));
    g1 = 24'(p3 >>> GF_FRAC);
    p3 = 40'(g1 * $signed({1'b0, half_w[H_GS + 32'(sel)]}));
    g2 = 24'(p3 >>> Q15);
    p1 = 40'(BP_C * (x2_q + sx));
    bp = 24'(x1_q) - 24'(p1 >>> TAB_FRAC);
    r16 = 16'((log2q(ori_e_q) - log2q(syn_e_q == 64'd0 ? 64'd1 : syn_e_q))
          >>> 1) + 16'(TAB_SCALE_LOG2 << LOG_FRAC);
    unique case (st_q)
      ST_IDLE:
        if (start_w)
        begin
          st_d = ST_TGT;
          {cnt_d, seg_cnt_d, seg_e_d, tot_e_d} = '0;
          {logsum_d, fprev_d, x1_d, x2_d, syn_e_d, ori_e_d} = '0;
          done_d = 1'b0;
          for (int k = 0; k < LPC_ORD; k++)
            yh_d[k] = 24'sd0;
        end
      ST_TGT:
        if (s_valid)
        begin
          seg_e_d = seg_e_q + 37'(sx * sx);
          tot_e_d = tot_e_q + 41'(sx * sx);
          seg_cnt_d = seg_cnt_q + 5'd1;
          if (seg_cnt_q == 5'(SEG_LEN - 1))
          begin
            logsum_d = logsum_q + 16'(log2q(64'(seg_e_d)));
            seg_e_d = 37'd0;
            seg_cnt_d = 5'd0;
          end
          cnt_d = cnt_q + 10'd1;
          if (cnt_q == 10'(FRAME_LEN - 1))
          begin
            cnt_d = 10'd0;
            st_d = ST_SYN;
          end
        end
      ST_SYN:
        if (s_valid)
        begin
          yh_d[0] = y;
          for (int k = 1; k < LPC_ORD; k++)
            yh_d[k] = yh_q[k-1];
          fprev_d = f;
          syn_e_d = syn_e_q + 64'(g2 * g2);
          cnt_d = cnt_q + 10'd1;
          if (cnt_q == 10'(FRAME_LEN - 1))
          begin
            cnt_d = 10'd0;
            st_d = ST_ORI;
          end
        end
      ST_ORI:
        if (s_valid)
        begin
          x2_d = x1_q;
          x1_d = sx;
          ori_e_d = ori_e_q + 64'(bp * bp);
          cnt_d = cnt_q + 10'd1;
          if (cnt_q == 10'(ORI_LEN - 1))
            st_d = ST_DONE;
        end
      ST_DONE:
      begin
        st_d = ST_IDLE;
        rv_d = 1'b1;
        done_d = 1'b1;
        flat_d = flag_w;
        code_d = flag_w ? 2'b01 : (onset_w == 2'd0 ? 2'b00
                 : (onset_w == 2'd1 ? 2'b10 : 2'b11));
        r16 = r16 + 16'sd8;
        // a silent input has no finite log; it must land at the floor
        if (r16 < 16'sd0 || ori_e_q == 64'd0)
          idx_d = 4'd0;
        else if ((r16 >>> LOG_FRAC) > 16'(IDX_MAX))
          idx_d = 4'(IDX_MAX);
        else
          idx_d = 4'(r16 >>> LOG_FRAC);
      end
      default:
        st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ST_IDLE;
      {cnt_q, seg_cnt_q, seg_e_q, tot_e_q} <= '0;
      {logsum_q, fprev_q, x1_q, x2_q, syn_e_q, ori_e_q} <= '0;
      for (int k = 0; k < LPC_ORD; k++)
        yh_q[k] <= 24'sd0;
      {done_q, rv_q, flat_q, code_q, idx_q} <= '0;
    end
    else if (ce)
    begin
      st_q <= st_d;
      {cnt_q, seg_cnt_q, seg_e_q, tot_e_q} <= {cnt_d, seg_cnt_d, seg_e_d,
                                               tot_e_d};
      {logsum_q, fprev_q, x1_q, x2_q} <= {logsum_d, fprev_d, x1_d, x2_d};
      {syn_e_q, ori_e_q} <= {syn_e_d, ori_e_d};
      yh_q <= yh_d;
      {done_q, rv_q, flat_q, code_q, idx_q} <= {done_d, rv_d, flat_d,
                                                code_d, idx_d};
    end
  end

  assign s_ready = st_q == ST_TGT || st_q == ST_SYN || st_q == ST_ORI;
  assign res_valid = rv_q;
  assign res_code = code_q;
  assign res_idx = idx_q;
  assign res_flat = flat_q;

  property p_code_flat;
    @(posedge clk) disable iff (!rst_n)
    res_valid |-> res_flat == (res_code == 2'b01);
  endproperty
  a_code_flat: assert property (p_code_flat)
    else $error("side code disagrees with flatness flag");
  property p_onset;
    @(posedge clk) disable iff (!rst_n)
    ce && st_q == ST_DONE && !flag_w |=>
      res_code == {$past(onset_w) != 2'd0, $past(onset_w) == 2'd2};
  endproperty
  a_onset: assert property (p_onset)
    else $error("side code does not follow onset flag");
  property p_tcx_gain;
    @(posedge clk) disable iff (!rst_n)
    ce && st_q == ST_DONE && regs_q[W_CTRL][CTRL_PREV_TCX]
      && gsum_w >= PGAIN_TH2 |=> !res_flat;
  endproperty
  a_tcx_gain: assert property (p_tcx_gain)
    else $error("flag set with high pitch gain after transform core");
  property p_lag;
    @(posedge clk) disable iff (!rst_n)
    ce && st_q == ST_DONE && !regs_q[W_CTRL][CTRL_PREV_TCX]
      && lsum_w <= LAG_TH2 |=> !res_flat;
  endproperty
  a_lag: assert property (p_lag)
    else $error("flag set with short pitch lag");
  property p_tgt_len;
    @(posedge clk) disable iff (!rst_n)
    ce && st_q == ST_TGT && s_valid && cnt_q == 10'(FRAME_LEN - 1)
      |=> st_q == ST_SYN && cnt_q == 10'd0;
  endproperty
  a_tgt_len: assert property (p_tgt_len)
    else $error("target phase length wrong");
  property p_syn_len;
    @(posedge clk) disable iff (!rst_n)
    ce && st_q == ST_SYN && s_valid && cnt_q == 10'(FRAME_LEN - 1)
      |=> st_q == ST_ORI;
  endproperty
  a_syn_len: assert property (p_syn_len)
    else $error("synthesis phase length wrong");
  property p_ori_len;
    @(posedge clk) disable iff (!rst_n)
    ce && st_q == ST_ORI && s_valid && cnt_q == 10'(ORI_LEN - 1)
      |=> st_q == ST_DONE ##1 res_valid;
  endproperty
  a_ori_len: assert property (p_ori_len)
    else $error("input phase length or result timing wrong");
  property p_mu;
    @(posedge clk) disable iff (!rst_n)
    mu_w >= MU_MIN && mu_w <= MU_MAX;
  endproperty
  a_mu: assert property (p_mu)
    else $error("de-emphasis factor out of bounds");
  property p_zero_ori;
    @(posedge clk) disable iff (!rst_n)
    ce && st_q == ST_DONE && ori_e_q == 64'd0 && syn_e_q > 64'd1
      |=> res_idx == 4'd0;
  endproperty
  a_zero_ori: assert property (p_zero_ori)
    else $error("energy index not clamped at zero");
  c_flat: cover property (@(posedge clk) res_valid && res_code == 2'b01);
  c_steep: cover property (@(posedge clk) res_valid && res_code == 2'b11);
  c_idx_max: cover property (@(posedge clk) res_valid && res_idx == 4'hF);
  c_write: cover property (@(posedge clk) s_axi_bvalid && s_axi_bready);
endmodule  // hbfe_top
`default_nettype wire

// ===== dv/hbfe_src.sv
/*
  hbfe_src: upstream sample source for hbfe_top.
  Assumes a caller that starts a frame right after a rising edge.
*/
`default_nettype none
module hbfe_src
(
  input  wire logic        clk,
  input  wire logic        s_ready,
  output logic             s_valid,
  output logic [15:0]      s_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    s_valid = 1'b0;
    s_data  = 16'h0000;
  end
  // random stalls; a stalled line shows the inverse of its last value
  task automatic put(input logic [15:0] v);
    logic rdy;
    while ($urandom_range(3) == 0)
    begin
      s_valid <= 1'b0;
      s_data  <= ~s_data;
      @(posedge clk);
    end
    s_valid <= 1'b1;
    s_data  <= v;
    rdy = 1'b0;
    while (!rdy)
    begin
      @(negedge clk);
      rdy = s_ready;
      @(posedge clk);
    end
  endtask
  task automatic send_frame(input logic flat, input logic quiet);
    for (int n = 0; n < 320; n++)
      put((flat || n < 20) ? 16'h03E8 : 16'h0000);
    for (int n = 0; n < 320; n++)
      put(quiet ? 16'h0000 : 16'($urandom));
    for (int n = 0; n < 960; n++)
      put(n[0] ? 16'h03E8 : 16'hFC18);
    s_valid <= 1'b0;
    s_data  <= 16'h5A5A;
  endtask
endmodule // hbfe_src
`default_nettype wire

// ===== dv/tb.sv
/*
  tb: self-checking bench for hbfe_top over AXI4-Lite and the stream.
  Assumes hbfe_src as sample source and ce held high.
*/
`default_nettype none
module tb
  import hbfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, ce, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic sv, sr, res_valid, res_flat;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd, d, v, w2, w;
  logic [3:0] ws, res_idx;
  logic [1:0] bresp, rresp, rsp, res_code;
  logic [15:0] sd;
  logic [2:0] e;
  int errors, tests_run;
  hbfe_top u_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_valid(sv), .s_ready(sr),
    .s_data(sd), .res_valid(res_valid), .res_code(res_code),
    .res_idx(res_idx), .res_flat(res_flat));
  hbfe_src u_src (.clk(clk), .s_ready(sr), .s_valid(sv), .s_data(sd));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dd,
                        input logic [3:0] st);
    logic ta, tw, b;
    awa <= a;
    wd  <= dd;
    ws  <= st;
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    b = 1'b0;
    while (!b)
    begin
      @(negedge clk);
      ta = awv & awr;
      tw = wv & wr;
      b = bv;
      rsp = bresp;
      @(posedge clk);
      if (ta)
        awv <= 1'b0;
      if (tw)
        wv <= 1'b0;
    end
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ta, r;
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    r = 1'b0;
    while (!r)
    begin
      @(negedge clk);
      ta = arv & arr;
      r = rv;
      d = rd;
      rsp = rresp;
      @(posedge clk);
      if (ta)
        arv <= 1'b0;
    end
  endtask
  // returns {flag, side code}
  function automatic logic [2:0] expect_fc(input logic [31:0] c);
    logic fl;
    logic [1:0] on;
    if (c[30])
      fl = c[31] && !c[26];
    else
      fl = c[31] && (int'(c[15:8]) + int'(c[7:0]) > 200) && c[26];
    on = c[27] ? (c[28] ? 2'd2 : 2'd0) : (c[29] ? 2'd1 : 2'd0);
    return {fl, fl ? 2'b01 : (on == 2'd0 ? 2'b00 : {1'b1, on == 2'd2})};
  endfunction
  task automatic tally_and_finish;
    if (errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // word: [31] flat target, [30] prev transform core, [29:27] onset
  // bits, [26] pitch gain 0.8 else 0.6, [15:8]/[7:0] half-frame lags
  logic [31:0] corner [0:6] = '{32'h8400_6466, 32'h9C00_6464,
    32'hE000_3232, 32'hE400_7878, 32'h2C00_7878, 32'h5000_7878,
    32'h9C00_7878};
  initial
  begin
    {rst_n, awv, wv, br, arv, rr, awa, ara, wd, ws} = '0;
    ce = 1'b1;
    errors = 0;
    tests_run = 0;
    void'($urandom(87));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 17; i++)
    begin
      axi_rd(8'(4 * i));
      check(d, 32'h0000_0000);
      check({30'h0, rsp}, {30'h0, i < 16 ? RESP_OKAY : RESP_SLVERR});
    end
    v = $urandom;
    w2 = $urandom;
    axi_wr(REG_LAG, v, 4'hF);
    axi_wr(REG_LAG, w2, 4'b0101);
    axi_rd(REG_LAG);
    check(d, {v[31:24], w2[23:16], v[15:8], w2[7:0]});
    axi_wr(REG_STAT, 32'hFFFF_FFFF, 4'hF);
    check({30'h0, rsp}, {30'h0, RESP_OKAY});
    axi_rd(REG_STAT);
    check(d, 32'h0000_0000);
    axi_wr(8'h44, 32'h0000_0001, 4'hF);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    for (int i = 0; i < 14; i++)
    begin
      w = corner[i % 7];
      if (i >= 7)
      begin
        w = $urandom;
        w[15:8] = 8'(90 + $urandom_range(20));
        w[7:0] = 8'(90 + $urandom_range(20));
      end
      e = expect_fc(w);
      axi_wr(REG_LAG, {8'h00, w[7:0], 8'h00, w[15:8]}, 4'hF);
      v = w[26] ? 32'h6666_6666 : 32'h4CCD_4CCD;
      axi_wr(REG_PGAIN, v, 4'hF);
      axi_wr(REG_FGAIN, $urandom, 4'hF);
      for (int k = 0; k < 5; k++)
        axi_wr(8'(REG_GS + 4 * k), $urandom, 4'hF);
      axi_wr(REG_LPC, {16'h0000, 16'($urandom_range(2047))}, 4'hF);
      axi_wr(REG_CTRL, {26'h0, w[29:27], 1'($urandom), w[30], 1'b1},
             4'hF);
      u_src.send_frame(w[31], i[0]);
      #1;
      check({31'h0, res_valid}, 32'h0000_0000);
      @(posedge clk);
      #1;
      check({31'h0, res_valid}, 32'h0000_0001);
      check({30'h0, res_code}, {30'h0, e[1:0]});
      check({31'h0, res_flat}, {31'h0, e[2]});
      // silent noise: synthetic energy floored, ratio saturates high
      if (i[0])
        check({28'h0, res_idx}, 32'h0000_000F);
      axi_rd(REG_STAT);
      v = {23'h0, e[2], i[0] ? 4'hF : 4'h0, e[1:0], 2'b10};
      check(i[0] ? d : d & 32'hFFFF_FF0F, v);
    end
    tally_and_finish();
  end
  initial
  begin
    #(20 * 80000);
    errors++;
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
